// >>> rtl/rtcc_pkg.sv
// rtcc_pkg: register map, reset values, field layouts and divider taps
// for the serial real-time clock/calendar core.
// Assumes a 32.768 kHz crystal level sampled in the mclk domain.
package rtcc_pkg;

    // Register addresses.
    localparam logic [3:0] ADDR_MAIN_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_FLAG_CTRL  = 4'h1;
    localparam logic [3:0] ADDR_SECONDS    = 4'h2;
    localparam logic [3:0] ADDR_HOURS      = 4'h4;
    localparam logic [3:0] ADDR_YEARS      = 4'h8;
    localparam logic [3:0] ADDR_ALM_MIN    = 4'h9;
    localparam logic [3:0] ADDR_ALM_HOUR   = 4'ha;
    localparam logic [3:0] ADDR_ALM_DAY    = 4'hb;
    localparam logic [3:0] ADDR_ALM_WDAY   = 4'hc;
    localparam logic [3:0] ADDR_CLKO_SEL   = 4'hd;
    localparam logic [3:0] ADDR_TMR_SETUP  = 4'he;
    localparam logic [3:0] ADDR_TMR_COUNT  = 4'hf;
    localparam int         REG_COUNT       = 16;
    localparam int         TIME_FIELDS     = 7;

    // Implemented bits per register, address 15 first.
    localparam logic [15:0][7:0] REG_MASK = {
        8'hff, 8'h83, 8'h07, 8'h87, 8'hbf, 8'hbf, 8'hff, 8'hff,
        8'h1f, 8'h07, 8'h3f, 8'h3f, 8'h7f, 8'hff, 8'hff, 8'hac};
    // Reset values per register, address 15 first.
    localparam logic [15:0][7:0] REG_RST = {
        8'h00, 8'h03, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00,
        8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h80, 8'h00, 8'h08};

    // Counting field limits for seconds .. years, years first.
    localparam logic [6:0][7:0] FIELD_MAX = {
        8'h99, 8'h12, 8'h06, 8'h31, 8'h23, 8'h59, 8'h59};
    localparam logic [6:0][7:0] FIELD_MIN = {
        8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    localparam logic [6:0][7:0] FIELD_MSK = {
        8'hff, 8'h1f, 8'h07, 8'h3f, 8'h3f, 8'h7f, 8'h7f};

    // Hour limits and field in 12-hour format.
    localparam logic [7:0] HR12_MSK = 8'h1f;
    localparam logic [7:0] HR12_MAX = 8'h12;
    localparam logic [7:0] HR12_MIN = 8'h01;
    localparam logic [7:0] HR12_ELEVEN = 8'h11;

    // Month lengths and calendar codes in BCD.
    localparam logic [7:0] DAYS_28 = 8'h28;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_31 = 8'h31;
    localparam logic [7:0] MON_FEB = 8'h02;
    localparam logic [7:0] MON_APR = 8'h04;
    localparam logic [7:0] MON_JUN = 8'h06;
    localparam logic [7:0] MON_SEP = 8'h09;
    localparam logic [7:0] MON_NOV = 8'h11;
    localparam logic [3:0] BCD_NINE = 4'h9;

    // Bit positions.
    localparam int C1_STOP = 5;
    localparam int C1_H12  = 2;
    localparam int C2_MI   = 7;
    localparam int C2_SI   = 6;
    localparam int C2_MSF  = 5;
    localparam int C2_AF   = 3;
    localparam int C2_TF   = 2;
    localparam int C2_AIE  = 1;
    localparam int C2_TIE  = 0;
    localparam int RF_BIT  = 7;
    localparam int AMPM_BIT = 5;
    localparam int AEN_BIT = 7;
    localparam int TE_BIT  = 7;
    localparam int CMD_RD_BIT = 7;

    // Crystal divider: 32768 edges give one second.
    localparam int XTAL_DIV_W = 15;
    localparam logic [14:0] PRE_M_4096 = 15'h0007;
    localparam logic [14:0] PRE_M_64   = 15'h01ff;
    localparam logic [14:0] PRE_M_1HZ  = 15'h7fff;

    // Divider taps for the clock output selections.
    localparam int TAP_16K = 0;
    localparam int TAP_8K  = 1;
    localparam int TAP_4K  = 2;
    localparam int TAP_1K  = 4;
    localparam int TAP_32  = 9;
    localparam int TAP_1HZ = 14;

    // Clock output and timer source codes.
    localparam logic [2:0] COF_32K = 3'h0;
    localparam logic [2:0] COF_16K = 3'h1;
    localparam logic [2:0] COF_8K  = 3'h2;
    localparam logic [2:0] COF_4K  = 3'h3;
    localparam logic [2:0] COF_1K  = 3'h4;
    localparam logic [2:0] COF_32  = 3'h5;
    localparam logic [2:0] COF_1HZ = 3'h6;
    localparam logic [1:0] SRC_4096 = 2'h0;
    localparam logic [1:0] SRC_64   = 2'h1;
    localparam logic [1:0] SRC_1HZ  = 2'h2;
    localparam logic [7:0] TMR_ONE  = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Serial port phases.
    typedef enum logic [1:0] {
        RTCC_CMD,
        RTCC_WRITE,
        RTCC_READ
    } rtcc_phase_t;

endpackage

// >>> rtl/rtcc_bcd_step.sv
// rtcc_bcd_step: next value of one BCD calendar field.
// Assumes the caller masks flag bits off the field before use.
`timescale 1ns/1ps

module rtcc_bcd_step
    import rtcc_pkg::*;
(
    input  wire logic [7:0] value,
    input  wire logic [7:0] max_val,
    input  wire logic [7:0] min_val,
    output logic      [7:0] next_value,
    output logic            at_max
);

    // Greater-or-equal lets an out-of-range write recover on its own.
    assign at_max = (value >= max_val);

    // Wrap to the minimum, carry into tens, or add one to the units.
    always_comb begin
        if (at_max) begin
            next_value = min_val;
        end else if (value[3:0] >= BCD_NINE) begin
            next_value = {4'(value[7:4] + 4'h1), 4'h0};
        end else begin
            next_value = 8'(value + 8'h01);
        end
    end

endmodule

// >>> rtl/rtcc_core.sv
// rtcc_core: real-time clock/calendar with a three-wire serial port.
// Assumes crystal_in and the serial pins are slow next to mclk and are
// already synchronous to it; open-drain pins are resolved outside.
`timescale 1ns/1ps

// Overview of operation
// - Sixteen byte registers, auto-incrementing pointer.
// - Addresses 00h, 01h are control registers.
// - Addresses 02h-08h hold seconds through years.
// - Time counters count in BCD.
// - Counters freeze while being read.
// - Addresses 09h-0Ch hold alarm match settings.
// - Address 0Dh selects open-drain clock output.
// - Addresses 0Eh, 0Fh run countdown, four sources.
// - Per-second and per-minute interrupts, enabled in 01h.
// - Crystal divider makes the one-second tick.
// - Interrupt line is active-low open-drain.
// - Read data leaves on push-pull serial_out.
// - Serial pins ignored while chip_select low.
// - Data pins may be tied into one line.
// - Every reset sets reset_flag in seconds.
// - Serial state restarts while chip_select low.
// - Unimplemented bits read back as zero.
// - Hours start in 24-hour format.
module rtcc_core
    import rtcc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic crystal_in,
    input  wire logic chip_select,
    input  wire logic bit_clock_in,
    input  wire logic serial_in,
    output logic      serial_out,
    output logic      serial_out_oe,
    output logic      irq_line_n_o,
    output logic      irq_line_n_oe,
    output logic      tick_output_pin_o,
    output logic      tick_output_pin_oe
);

    // Register file, one byte per address.
    logic [7:0]            regs [REG_COUNT];
    // Countdown value reloaded after each underflow.
    logic [7:0]            tmr_reload;

    // Serial port state.
    rtcc_phase_t           phase;
    logic [2:0]            bit_cnt;     // Bits taken in this byte.
    logic [6:0]            shift_in;    // Bits gathered so far.
    logic [3:0]            ptr;         // Register pointer.
    logic [7:0]            tx;          // Outgoing read byte.
    logic                  sclk_d;      // Bit clock one cycle ago.
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic [7:0]            rx_byte;
    logic                  byte_done;
    logic                  wr_en;
    logic [3:0]            load_addr;

    // Timebase state.
    logic                  xtal_d;      // Crystal level one cycle ago.
    logic                  xtal_edge;
    logic [XTAL_DIV_W-1:0] pre;         // Crystal divider.
    logic                  sec_tick;
    logic                  sec_pend;    // Second waiting to be counted.
    logic                  hold;        // Counters frozen for a read.
    logic                  stop;
    logic                  h12;

    // Calendar stepping.
    logic [6:0]            adv;         // Field advances this cycle.
    logic [6:0]            wrap;        // Field at its maximum.
    logic [7:0]            f_val [TIME_FIELDS];
    logic [7:0]            f_nxt [TIME_FIELDS];
    logic [7:0]            f_max [TIME_FIELDS];
    logic [7:0]            f_min [TIME_FIELDS];
    logic [7:0]            f_msk [TIME_FIELDS];
    logic                  day_roll;

    // Alarm, timer and output state.
    logic                  alarm_hit;
    logic                  alarm_d;     // Alarm match one cycle ago.
    logic                  tmr_src;
    logic                  tmr_fire;
    logic                  clko_level;
    logic                  irq_active;

    assign stop = regs[ADDR_MAIN_CTRL][C1_STOP];
    assign h12  = regs[ADDR_MAIN_CTRL][C1_H12];

    // Serial input decode; every edge is gated by chip_select so a
    // floating bus outside a transfer never moves anything.
    assign sclk_rise = chip_select & bit_clock_in & ~sclk_d;
    assign sclk_fall = chip_select & ~bit_clock_in & sclk_d;
    assign rx_byte   = {shift_in, serial_in};
    assign byte_done = sclk_rise & (bit_cnt == BIT_LAST);
    assign wr_en     = byte_done & (phase == RTCC_WRITE);
    // Next register to present: the command's start or the next one.
    assign load_addr = (phase == RTCC_CMD) ? rx_byte[3:0]
                                           : 4'(ptr + 4'h1);

    // The bit clock is sampled every cycle; only gated edges count.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= bit_clock_in;
        end
    end

    // Command and data byte framing, bits taken on rising edges.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase    <= RTCC_CMD;
            bit_cnt  <= 3'h0;
            shift_in <= 7'h00;
            ptr      <= 4'h0;
        end else if (!chip_select) begin
            // Any partial command is dropped between transfers.
            phase   <= RTCC_CMD;
            bit_cnt <= 3'h0;
        end else if (sclk_rise) begin
            bit_cnt  <= 3'(bit_cnt + 3'h1);
            shift_in <= rx_byte[6:0];
            if (bit_cnt == BIT_LAST) begin
                case (phase)
                    RTCC_CMD: begin
                        // Direction bit, then start address.
                        phase <= rx_byte[CMD_RD_BIT] ? RTCC_READ
                                                     : RTCC_WRITE;
                        ptr   <= rx_byte[3:0];
                    end
                    RTCC_WRITE, RTCC_READ: begin
                        ptr <= 4'(ptr + 4'h1);
                    end
                    default: begin
                        phase <= RTCC_CMD;
                    end
                endcase
            end
        end
    end

    // Read byte loads at each byte end and shifts out on falling edges,
    // except the falling edge right after a load, which would lose the
    // first bit before the host has sampled it.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx <= BYTE_ZERO;
        end else if (byte_done) begin
            tx <= regs[load_addr];
        end else if (sclk_fall && bit_cnt != 3'h0) begin
            tx <= {tx[6:0], 1'b0};
        end
    end

    // Push-pull data out, enabled only in the read phase so that the
    // host may join serial_in and serial_out into one wire.
    assign serial_out    = tx[7];
    assign serial_out_oe = chip_select & (phase == RTCC_READ);

    // Counters are held from the end of a read command until deselect.
    assign hold = chip_select & (phase == RTCC_READ);

    // Crystal divider; stopping the clock also clears the divider so a
    // restart begins a full second later.
    assign xtal_edge = crystal_in & ~xtal_d;
    assign sec_tick  = xtal_edge & (pre == PRE_M_1HZ);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            xtal_d <= 1'b0;
            pre    <= '0;
        end else begin
            xtal_d <= crystal_in;
            if (stop) begin
                pre <= '0;
            end else if (xtal_edge) begin
                pre <= XTAL_DIV_W'(pre + 1'b1);
            end
        end
    end

    // A second that lands during a read waits here; only one can wait,
    // so a read held open longer than a second loses time.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sec_pend <= 1'b0;
        end else if (sec_tick && !stop) begin
            sec_pend <= 1'b1;
        end else if (!hold) begin
            sec_pend <= 1'b0;
        end
    end

    // Days in the current month; leap years are multiples of four.
    function automatic logic [7:0] month_days(input logic [7:0] mon,
                                              input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[1:0] == 2'h2) : (yr[1:0] == 2'h0);
        if (mon == MON_FEB) begin
            month_days = leap ? DAYS_29 : DAYS_28;
        end else if (mon == MON_APR || mon == MON_JUN ||
                     mon == MON_SEP || mon == MON_NOV) begin
            month_days = DAYS_30;
        end else begin
            month_days = DAYS_31;
        end
    endfunction

    // Field limits; hours and days depend on format and calendar.
    always_comb begin
        for (int i = 0; i < TIME_FIELDS; i++) begin
            f_max[i] = FIELD_MAX[i];
            f_min[i] = FIELD_MIN[i];
            f_msk[i] = FIELD_MSK[i];
        end
        if (h12) begin
            f_max[2] = HR12_MAX;
            f_min[2] = HR12_MIN;
            f_msk[2] = HR12_MSK;
        end
        f_max[3] = month_days(f_val[5], f_val[6]);
    end

    // One BCD stepper for each calendar field.
    for (genvar i = 0; i < TIME_FIELDS; i++) begin : g_field
        assign f_val[i] = regs[int'(ADDR_SECONDS) + i] & f_msk[i];
        rtcc_bcd_step u_step (
            .value      (f_val[i]),
            .max_val    (f_max[i]),
            .min_val    (f_min[i]),
            .next_value (f_nxt[i]),
            .at_max     (wrap[i])
        );
    end

    // Carry chain from seconds up to years; weekday moves with days.
    assign day_roll = h12 ? (adv[2] && f_val[2] == HR12_ELEVEN &&
                             regs[ADDR_HOURS][AMPM_BIT])
                          : (adv[2] & wrap[2]);
    assign adv[0] = sec_pend & ~hold;
    assign adv[1] = adv[0] & wrap[0];
    assign adv[2] = adv[1] & wrap[1];
    assign adv[3] = day_roll;
    assign adv[4] = day_roll;
    assign adv[5] = day_roll & wrap[3];
    assign adv[6] = adv[5] & wrap[5];

    // A disabled alarm field (enable bit high) always matches; with all
    // fields disabled the alarm never fires.
    always_comb begin
        alarm_hit = ~(regs[ADDR_ALM_MIN][AEN_BIT] &
                      regs[ADDR_ALM_HOUR][AEN_BIT] &
                      regs[ADDR_ALM_DAY][AEN_BIT] &
                      regs[ADDR_ALM_WDAY][AEN_BIT]);
        for (int i = 0; i < 4; i++) begin
            if (!regs[int'(ADDR_ALM_MIN) + i][AEN_BIT] &&
                (regs[int'(ADDR_ALM_MIN) + i] & f_msk[i + 1]) !=
                f_val[i + 1]) begin
                alarm_hit = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_d <= 1'b0;
        end else begin
            alarm_d <= alarm_hit;
        end
    end

    // Countdown source: 4096 Hz, 64 Hz, 1 Hz or one per minute.
    always_comb begin
        case (regs[ADDR_TMR_SETUP][1:0])
            SRC_4096: tmr_src = xtal_edge &&
                                (pre & PRE_M_4096) == PRE_M_4096;
            SRC_64:   tmr_src = xtal_edge &&
                                (pre & PRE_M_64) == PRE_M_64;
            SRC_1HZ:  tmr_src = sec_tick;
            default:  tmr_src = adv[1];
        endcase
    end
    assign tmr_fire = regs[ADDR_TMR_SETUP][TE_BIT] & tmr_src;

    // Reload value follows every host write of the count register.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tmr_reload <= REG_RST[ADDR_TMR_COUNT];
        end else if (wr_en && ptr == ADDR_TMR_COUNT) begin
            tmr_reload <= rx_byte;
        end
    end

    // Register file. Order matters: counting first, then a host write
    // (so software time wins over a tick), then flag sets (so an event
    // in the cycle of its clear is kept).
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int a = 0; a < REG_COUNT; a++) begin
                // Reset value carries reset_flag and 24-hour mode.
                regs[a] <= REG_RST[a];
            end
        end else begin
            for (int i = 0; i < TIME_FIELDS; i++) begin
                if (adv[i]) begin
                    // Flag bits beside the field are kept.
                    regs[int'(ADDR_SECONDS) + i] <=
                        (regs[int'(ADDR_SECONDS) + i] & ~f_msk[i]) |
                        f_nxt[i];
                end
            end
            if (h12 && adv[2] && f_val[2] == HR12_ELEVEN) begin
                regs[ADDR_HOURS][AMPM_BIT] <=
                    ~regs[ADDR_HOURS][AMPM_BIT];
            end
            if (tmr_fire) begin
                if (regs[ADDR_TMR_COUNT] == TMR_ONE) begin
                    regs[ADDR_TMR_COUNT] <= tmr_reload;
                end else if (regs[ADDR_TMR_COUNT] != BYTE_ZERO) begin
                    regs[ADDR_TMR_COUNT] <=
                        8'(regs[ADDR_TMR_COUNT] - TMR_ONE);
                end
            end
            if (wr_en) begin
                regs[ptr] <= rx_byte & REG_MASK[ptr];
            end
            if ((adv[0] && regs[ADDR_FLAG_CTRL][C2_SI]) ||
                (adv[1] && regs[ADDR_FLAG_CTRL][C2_MI])) begin
                regs[ADDR_FLAG_CTRL][C2_MSF] <= 1'b1;
            end
            if (alarm_hit && !alarm_d) begin
                regs[ADDR_FLAG_CTRL][C2_AF] <= 1'b1;
            end
            if (tmr_fire && regs[ADDR_TMR_COUNT] == TMR_ONE) begin
                regs[ADDR_FLAG_CTRL][C2_TF] <= 1'b1;
            end
        end
    end

    // Interrupt: a raised flag whose source is enabled pulls low.
    assign irq_active =
        (regs[ADDR_FLAG_CTRL][C2_MSF] &
         (regs[ADDR_FLAG_CTRL][C2_SI] | regs[ADDR_FLAG_CTRL][C2_MI])) |
        (regs[ADDR_FLAG_CTRL][C2_AF] & regs[ADDR_FLAG_CTRL][C2_AIE]) |
        (regs[ADDR_FLAG_CTRL][C2_TF] & regs[ADDR_FLAG_CTRL][C2_TIE]);
    assign irq_line_n_o  = 1'b0;
    assign irq_line_n_oe = irq_active;

    // Clock output selection; code 7 leaves the pin released.
    always_comb begin
        case (regs[ADDR_CLKO_SEL][2:0])
            COF_32K: clko_level = xtal_d;
            COF_16K: clko_level = pre[TAP_16K];
            COF_8K:  clko_level = pre[TAP_8K];
            COF_4K:  clko_level = pre[TAP_4K];
            COF_1K:  clko_level = pre[TAP_1K];
            COF_32:  clko_level = pre[TAP_32];
            COF_1HZ: clko_level = pre[TAP_1HZ];
            default: clko_level = 1'b1;
        endcase
    end

    // Open drain: only the low half of the wave is driven.
    assign tick_output_pin_o  = 1'b0;
    assign tick_output_pin_oe = ~clko_level;

endmodule

// >>> dv/rtcc_core_monitor.sv
// rtcc_core_monitor: port assertions for the clock/calendar core.
// Assumes crystal_in stays low until reset_n is released.
`timescale 1ns/1ps
module rtcc_core_monitor (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic crystal_in,
    input wire logic chip_select,
    input wire logic bit_clock_in,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic irq_line_n_o,
    input wire logic irq_line_n_oe,
    input wire logic tick_output_pin_o,
    input wire logic tick_output_pin_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Open-drain pins may only ever pull low.
    irq_drain_only_a:
        assert property (irq_line_n_o == 1'b0) else $error("irq high");
    tick_drain_only_a:
        assert property (tick_output_pin_o == 1'b0) else $error("tick high");
    out_quiet_idle_a:
        assert property (!chip_select |-> !serial_out_oe)
        else $error("serial_out driven while idle");
    out_enable_cause_a:
        assert property ($rose(serial_out_oe) |->
            $past(chip_select) && $past(bit_clock_in))
        else $error("read enable without a bit clock rise");
    out_enable_hold_a:
        assert property ($fell(serial_out_oe) |-> !chip_select)
        else $error("read enable dropped in frame");
    // Read data may only move shortly after a bit clock edge.
    out_bit_timing_a:
        assert property ($changed(serial_out) && chip_select &&
            $past(serial_out_oe) |-> $past(bit_clock_in) !=
            $past(bit_clock_in, 4))
        else $error("serial_out moved without a clock edge");
    // Flags rise from a register write or a crystal-derived tick.
    irq_cause_a:
        assert property ($rose(irq_line_n_oe) |-> $past(chip_select) ||
            $past(crystal_in) != $past(crystal_in, 4))
        else $error("interrupt without cause");
    // The clock output moves one cycle after the crystal edge it follows,
    // whatever the crystal rate.
    tick_cause_a:
        assert property ($changed(tick_output_pin_oe) |-> $past(chip_select)
            || $past(crystal_in) != $past(crystal_in, 2))
        else $error("clock output moved without crystal edge");
endmodule

bind rtcc_core rtcc_core_monitor u_monitor (
    .mclk(mclk), .reset_n(reset_n), .crystal_in(crystal_in),
    .chip_select(chip_select), .bit_clock_in(bit_clock_in),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .irq_line_n_o(irq_line_n_o),
    .irq_line_n_oe(irq_line_n_oe), .tick_output_pin_o(tick_output_pin_o),
    .tick_output_pin_oe(tick_output_pin_oe));

// >>> dv/rtcc_host.sv
// rtcc_host: serial bus master in the host controller's place.
// Assumes mclk at 50 MHz; one bit takes 9 mclk, about 5.6 Mbit/s.
`timescale 1ns/1ps
module rtcc_host (
    input  wire logic mclk,
    input  wire logic serial_out,
    output logic      chip_select,
    output logic      bit_clock_in,
    output logic      serial_in
);
    logic [7:0] data [16]; // Bytes to send; read bytes land here.
    // Idle: deselected with the bit clock parked low.
    initial begin
        chip_select  = 1'b0;
        bit_clock_in = 1'b0;
        serial_in    = 1'b0;
    end
    // MSB first; 5 low and 4 high mclk stay under 6.0 Mbit/s.
    task automatic shift(input logic [7:0] w, output logic [7:0] r,
                         input int nb);
        r = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            @(posedge mclk);
            bit_clock_in <= 1'b0;
            serial_in    <= w[i];
            repeat (5) @(posedge mclk);
            bit_clock_in <= 1'b1;
            r[i] = serial_out;
            repeat (3) @(posedge mclk);
        end
    endtask
    // Command, then n bytes; the last is cut to nb bits for aborts.
    task automatic xfer(input logic [7:0] cmd, input int n, input int nb);
        logic [7:0] r;
        @(posedge mclk);
        chip_select <= 1'b1;
        shift(cmd, r, 8);
        for (int k = 0; k < n; k++)
            shift(data[k], data[k], (k == n - 1) ? nb : 8);
        @(posedge mclk);
        bit_clock_in <= 1'b0;
        @(posedge mclk);
        chip_select <= 1'b0;
        serial_in   <= ~serial_in; // A released line keeps no value.
    endtask
endmodule

// >>> dv/rtcc_core_tb.sv
// rtcc_core_tb: register tests of the clock/calendar core.
// Assumes rtcc_host as bus master and the bound port monitor.
`timescale 1ns/1ps
module rtcc_core_tb
    import rtcc_pkg::*;
;
    logic       mclk = 1'b0;
    logic       reset_n = 1'b0;
    logic       crystal_in = 1'b0;
    logic       xtal_run = 1'b0;
    logic [7:0] tv [9] = '{8'h00, 8'h00, 8'h59, 8'h59, 8'h23, 8'h31,
                           8'h06, 8'h12, 8'h99}; // Time image from 00h.
    wire        chip_select, bit_clock_in, serial_in, serial_out;
    wire        serial_out_oe, irq_line_n_o, irq_line_n_oe;
    wire        tick_output_pin_o, tick_output_pin_oe;
    int         n_mismatch = 0;
    int         checked = 0;

    always #10 mclk = ~mclk;
    // Crystal stand-in at half of mclk: one second is 65536 mclk.
    always @(posedge mclk) begin
        if (xtal_run)
            crystal_in <= ~crystal_in;
    end
    rtcc_core u_dut (.mclk(mclk), .reset_n(reset_n),
        .crystal_in(crystal_in), .chip_select(chip_select),
        .bit_clock_in(bit_clock_in), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .irq_line_n_o(irq_line_n_o), .irq_line_n_oe(irq_line_n_oe),
        .tick_output_pin_o(tick_output_pin_o),
        .tick_output_pin_oe(tick_output_pin_oe));
    rtcc_host u_host (.mclk(mclk), .serial_out(serial_out),
        .chip_select(chip_select), .bit_clock_in(bit_clock_in),
        .serial_in(serial_in));

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic results;
        if (n_mismatch == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Tests need about 70000 mclk, mostly waiting for the first second.
    initial begin
        #(20 * 90000);
        n_mismatch++;
        results();
    end
    initial begin
        repeat (3) @(posedge mclk);
        check(tick_output_pin_oe, 8'h01);
        check(irq_line_n_oe, 8'h00);
        reset_n  <= 1'b1;
        xtal_run <= 1'b1;
        u_host.xfer(8'h80, 16, 8);
        for (int k = 0; k < REG_COUNT; k++)
            check(u_host.data[k], REG_RST[k]);
        // All ones from 09h wraps past 0Fh to 00h; blanks read zero.
        for (int k = 0; k < 8; k++)
            u_host.data[k] = 8'hff;
        u_host.xfer(8'h09, 8, 8);
        check(tick_output_pin_oe, 8'h00);
        u_host.xfer(8'h89, 8, 8);
        for (int k = 0; k < 8; k++)
            check(u_host.data[k], REG_MASK[(9 + k) % 16]);
        for (int k = 0; k < 9; k++)
            u_host.data[k] = tv[k];
        u_host.xfer(8'h00, 9, 8);
        u_host.xfer(8'h80, 9, 8);
        for (int k = 0; k < 9; k++)
            check(u_host.data[k], tv[k]);
        // Countdown of 2 at 4096 Hz with its interrupt enabled.
        u_host.data[0] = 8'h01;
        u_host.xfer(8'h01, 1, 8);
        u_host.data[0] = 8'h00;
        u_host.data[1] = 8'h80;
        u_host.data[2] = 8'h02;
        u_host.xfer(8'h0d, 3, 8);
        for (int k = 0; k < 500 && irq_line_n_oe !== 1'b1; k++)
            @(posedge mclk);
        check(irq_line_n_oe, 8'h01);
        u_host.xfer(8'h81, 1, 8);
        check(u_host.data[0], 8'h05);
        u_host.data[0] = 8'h00;
        u_host.xfer(8'h01, 1, 8);
        check(irq_line_n_oe, 8'h00);
        // A byte cut short by deselect must not land.
        u_host.data[0] = 8'hff;
        u_host.xfer(8'h0d, 1, 4);
        u_host.xfer(8'h8d, 1, 8);
        check(u_host.data[0], 8'h00);
        // Per-second interrupt; 23:59:59 on the last day of 99 rolls
        // every field over to its lowest value.
        u_host.data[0] = 8'h40;
        u_host.xfer(8'h01, 1, 8);
        for (int k = 0; k < 70000 && irq_line_n_oe !== 1'b1; k++)
            @(posedge mclk);
        check(irq_line_n_oe, 8'h01);
        u_host.xfer(8'h82, TIME_FIELDS, 8);
        for (int k = 0; k < TIME_FIELDS; k++)
            check(u_host.data[k], FIELD_MIN[k]);
        results();
    end
endmodule
